// ---- verilog/cca_counter_array.sv ----
/*
  Counter array: 16-bit counter with selectable timebase, overflow flag,
  and six capture/compare modules with capture and software timer.
  Assumes a single 50 MHz clock, a one-cycle register port with read data
  in the next cycle, and pin inputs that are asynchronous to clk.
*/
// Function
// R1: Low-byte read snapshots high byte for next read
// R2: Counter reads never disturb counting
// R3: Timebase select picks one of six increments
// R4: External count input no faster than clk/4
// R5: Oscillator/8 timebase synchronised before counting
// R6: Wrap from all-ones to zero sets overflow flag
// R7: Overflow interrupt only when its enable set
// R8: Overflow flag stays set until software clears
// R9: Interrupts need global and array enables
// R10: Idle-suspend clear keeps counting in idle
// R11: Control write during overflow loses the flag
// R12: Software rechecks counter around control bit ops
// R13: Six modules, each 16-bit register and line
// R14: Capture edge chosen by rise/fall bits
// R15: Comparator mode decode: timer, fast, frequency; code decodes only the timer match
// R16: Wide select picks 8 or 16-bit PWM; code has no PWM output, wide_pwm is only stored
// R17: Module event interrupt needs module enable
// R18: Capture copies counter and sets event flag
// R19: Capture input held two cycles to count
// R20: Software timer sets flag on counter match
// R21: Event flags stay set until software clears
// R22: Low-byte write clears, high-byte sets comparator
// R23: Idle-suspend set halts array in idle; code stops only the counter, captures still occur
// R24: Counter advances only while run control set
`timescale 1ns/1ps

module cca_counter_array #(
  parameter int NUM_MOD = 6
) (
  input wire logic clk,
  input wire logic sys_rst,
  input cca_pkg::cca_req_t req,
  output logic [7:0] rd_data,
  input wire logic timer0_ovf,
  input wire logic ext_count_in,
  input wire logic ext_osc_in,
  input wire logic [NUM_MOD-1:0] module_io_line,
  input wire logic cpu_idle,
  input wire logic global_irq_enable,
  input wire logic array_irq_enable,
  output logic irq
);

  cca_pkg::cca_state_t q;
  cca_pkg::cca_state_t d;

  // Helpers shared by the update and the checks
  logic [7:0] lvl_n;
  logic [7:0] rise;
  logic [7:0] fall;
  logic run;
  logic tick;
  logic inc;
  logic [15:0] cnt_inc;
  logic [NUM_MOD-1:0] cap_evt;
  logic [NUM_MOD-1:0] match_evt;
  logic [NUM_MOD-1:0] evt_ie_v;
  logic ctrl_wr;

  // Pin level accepted once second and third stage agree
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      lvl_n[i] = (q.s2[i] == q.s3[i]) ? q.s3[i] : q.lvl[i]; // R19
    end
  end

  assign rise = lvl_n & ~q.lvl;
  assign fall = ~lvl_n & q.lvl;
  assign run = q.run_ctl & ~(q.idle_susp & cpu_idle); // R10 R23 R24
  assign inc = run & tick;
  assign cnt_inc = q.cnt + 16'h0001;
  assign ctrl_wr = req.wr && (req.addr == cca_pkg::ADDR_CTRL);

  // Timebase selection
  always_comb begin
    case (q.tb_sel) // R3
      cca_pkg::TB_SYS12: tick = (q.pre == cca_pkg::PRE_LAST);
      cca_pkg::TB_SYS4: tick = (q.pre[1:0] == cca_pkg::PRE4_LAST);
      cca_pkg::TB_T0: tick = timer0_ovf;
      cca_pkg::TB_EXTCNT: tick = fall[cca_pkg::IN_EXTCNT];
      cca_pkg::TB_SYS: tick = 1'b1;
      cca_pkg::TB_OSC8: tick = rise[cca_pkg::IN_OSC] &&
        (q.osc_div == cca_pkg::OSC_DIV_LAST); // R5
      default: tick = 1'b0;
    endcase
  end

  // Module events: capture and comparator match
  always_comb begin
    for (int i = 0; i < NUM_MOD; i++) begin
      cap_evt[i] = ~q.mode[i].match_en & ~q.mode[i].toggle_en &
        ~q.mode[i].pwm_en &
        ((q.mode[i].cap_rise & rise[i]) |
         (q.mode[i].cap_fall & fall[i])); // R14 R18
      match_evt[i] = inc & q.mode[i].cmp_en & q.mode[i].match_en &
        (cnt_inc == q.cc[i]); // R15 R20
      evt_ie_v[i] = q.mode[i].evt_ie;
    end
  end

  // Next state
  always_comb begin
    d = q;
    // Three-stage synchroniser, filtered level
    d.s1 = {ext_osc_in, ext_count_in, module_io_line};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.lvl = lvl_n;
    d.rdata = cca_pkg::RST_BYTE;
    // Shared divider for clk/12 and clk/4
    d.pre = (q.pre == cca_pkg::PRE_LAST) ? 4'h0 : q.pre + 4'h1;
    if (rise[cca_pkg::IN_OSC]) begin
      d.osc_div = q.osc_div + 3'h1;
    end
    // Counting and overflow
    if (inc) begin
      d.cnt = cnt_inc; // R2
      if (q.cnt == cca_pkg::CNT_MAX) begin
        d.ovf_flag = 1'b1; // R6 R8
      end
    end
    // Capture copies the current count
    for (int i = 0; i < NUM_MOD; i++) begin
      if (cap_evt[i]) begin
        d.cc[i] = q.cnt; // R13 R18
      end
    end
    d.evt_flag = q.evt_flag | cap_evt | match_evt; // R21
    // Register writes
    if (req.wr) begin
      case (req.addr)
        cca_pkg::ADDR_CTRL: begin
          d.ovf_flag = req.wdata[cca_pkg::CTRL_OVF_BIT]; // R11
          d.run_ctl = req.wdata[cca_pkg::CTRL_RUN_BIT];
          d.evt_flag = req.wdata[NUM_MOD-1:0] | cap_evt | match_evt; // R21
        end
        cca_pkg::ADDR_MODE: begin
          d.idle_susp = req.wdata[cca_pkg::MODE_IDLE_BIT];
          d.tb_sel = req.wdata[cca_pkg::MODE_TB_LSB +: 3];
          d.ovf_ie = req.wdata[cca_pkg::MODE_IE_BIT];
        end
        cca_pkg::ADDR_CNT_LO: d.cnt[7:0] = req.wdata;
        cca_pkg::ADDR_CNT_HI: d.cnt[15:8] = req.wdata;
        default: begin
        end
      endcase
      for (int i = 0; i < NUM_MOD; i++) begin
        if (req.addr == 5'(cca_pkg::ADDR_MMODE0 + i)) begin
          d.mode[i] = req.wdata; // R15 R16
        end
        if (req.addr == 5'(cca_pkg::ADDR_CCLO0 + i) && !cap_evt[i]) begin
          d.cc[i][7:0] = req.wdata;
          d.mode[i].cmp_en = 1'b0; // R22
        end
        if (req.addr == 5'(cca_pkg::ADDR_CCHI0 + i) && !cap_evt[i]) begin
          d.cc[i][15:8] = req.wdata;
          d.mode[i].cmp_en = 1'b1; // R22
        end
      end
    end
    // Register reads
    if (req.rd) begin
      case (req.addr)
        cca_pkg::ADDR_CTRL: d.rdata = {q.ovf_flag, q.run_ctl,
          q.evt_flag};
        cca_pkg::ADDR_MODE: d.rdata = {q.idle_susp, 3'h0, q.tb_sel,
          q.ovf_ie};
        cca_pkg::ADDR_CNT_LO: begin
          d.rdata = q.cnt[7:0];
          d.snap = q.cnt[15:8]; // R1
        end
        cca_pkg::ADDR_CNT_HI: d.rdata = q.snap; // R1
        default: begin
        end
      endcase
      for (int i = 0; i < NUM_MOD; i++) begin
        if (req.addr == 5'(cca_pkg::ADDR_MMODE0 + i)) begin
          d.rdata = q.mode[i];
        end
        if (req.addr == 5'(cca_pkg::ADDR_CCLO0 + i)) begin
          d.rdata = q.cc[i][7:0];
        end
        if (req.addr == 5'(cca_pkg::ADDR_CCHI0 + i)) begin
          d.rdata = q.cc[i][15:8];
        end
      end
    end
    // Combined interrupt request
    d.irq = global_irq_enable & array_irq_enable &
      ((q.ovf_flag & q.ovf_ie) | |(q.evt_flag & evt_ie_v)); // R7 R9 R17
  end

  // State register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rd_data = q.rdata;
  assign irq = q.irq;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  snap_latch_a: assert property ( // R1
    req.rd && req.addr == cca_pkg::ADDR_CNT_LO ##1
    req.rd && req.addr == cca_pkg::ADDR_CNT_HI
    |=> rd_data == $past(q.cnt[15:8], 2))
    else $error("high byte read did not return snapshot");

  read_nodisturb_a: assert property ( // R2
    req.rd && !req.wr && inc |=> q.cnt == $past(cnt_inc))
    else $error("counter disturbed by a read");

  sys_count_a: assert property ( // R3
    q.tb_sel == cca_pkg::TB_SYS && run && !req.wr
    |=> q.cnt == $past(q.cnt) + 16'h0001)
    else $error("clk timebase failed to count");

  run_hold_a: assert property ( // R24
    !q.run_ctl && !req.wr |=> $stable(q.cnt))
    else $error("counter moved while stopped");

  idle_hold_a: assert property ( // R23
    q.idle_susp && cpu_idle && !req.wr |=> $stable(q.cnt))
    else $error("counter moved in suspended idle");

  ovf_set_a: assert property ( // R6
    inc && q.cnt == cca_pkg::CNT_MAX && !ctrl_wr
    |=> q.ovf_flag && q.cnt == 16'h0000)
    else $error("overflow flag not set on wrap");

  ovf_lost_a: assert property ( // R11
    inc && q.cnt == cca_pkg::CNT_MAX && ctrl_wr &&
    !req.wdata[cca_pkg::CTRL_OVF_BIT] |=> !q.ovf_flag)
    else $error("overflow flag set despite control write");

  ovf_sticky_a: assert property ( // R8
    q.ovf_flag && !ctrl_wr |=> q.ovf_flag)
    else $error("overflow flag cleared without software");

  irq_gate_a: assert property ( // R9
    !(global_irq_enable && array_irq_enable) |=> !irq)
    else $error("interrupt raised while disabled");

  irq_ovf_a: assert property ( // R7
    global_irq_enable && array_irq_enable && q.ovf_flag &&
    q.ovf_ie |=> irq)
    else $error("overflow interrupt missing");

  capture_a: assert property ( // R18
    cap_evt[0] |=> q.cc[0] == $past(q.cnt) && q.evt_flag[0])
    else $error("capture did not load module 0");

  match_flag_a: assert property ( // R20
    match_evt[0] |=> q.evt_flag[0] && q.cnt == q.cc[0])
    else $error("match did not set module 0 flag");

  lo_write_a: assert property ( // R22
    req.wr && req.addr == cca_pkg::ADDR_CCLO0 && !cap_evt[0]
    |=> !q.mode[0].cmp_en ##1 1'b1)
    else $error("low byte write left comparator on");

  cap_cov: cover property (cap_evt[0] ##1 q.evt_flag[0]);
  match_cov: cover property (match_evt[0] ##1 irq);
  ovf_cov: cover property (inc && q.cnt == cca_pkg::CNT_MAX ##1 q.ovf_flag);
  snap_cov: cover property (req.rd && req.addr == cca_pkg::ADDR_CNT_HI);

endmodule

// ---- verilog/cca_pkg.sv ----
/*
  Package for the counter array with six capture/compare modules:
  register offsets, field layouts, timebase codes and the state record.
  Assumes an 8-bit register port addressed by a 5-bit byte index.
*/
package cca_pkg;

  // Register offsets
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_MODE = 5'h01;
  localparam logic [4:0] ADDR_CNT_LO = 5'h02;
  localparam logic [4:0] ADDR_CNT_HI = 5'h03;
  localparam logic [4:0] ADDR_MMODE0 = 5'h04;
  localparam logic [4:0] ADDR_CCLO0 = 5'h0a;
  localparam logic [4:0] ADDR_CCHI0 = 5'h10;

  // Field positions in the control and mode registers
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  localparam int MODE_IDLE_BIT = 7;
  localparam int MODE_TB_LSB = 1;
  localparam int MODE_IE_BIT = 0;

  // Timebase select codes
  localparam logic [2:0] TB_SYS12 = 3'h0;
  localparam logic [2:0] TB_SYS4 = 3'h1;
  localparam logic [2:0] TB_T0 = 3'h2;
  localparam logic [2:0] TB_EXTCNT = 3'h3;
  localparam logic [2:0] TB_SYS = 3'h4;
  localparam logic [2:0] TB_OSC8 = 3'h5;

  // Divider and counter limits
  localparam logic [3:0] PRE_LAST = 4'hb;
  localparam logic [1:0] PRE4_LAST = 2'h3;
  localparam logic [2:0] OSC_DIV_LAST = 3'h7;
  localparam logic [15:0] CNT_MAX = 16'hffff;

  // Input bit positions in the synchroniser vector
  localparam int IN_EXTCNT = 6;
  localparam int IN_OSC = 7;

  // Reset value of every register
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Register port request
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cca_req_t;

  // Module mode register, bit 7 down to bit 0
  typedef struct packed {
    logic wide_pwm;
    logic cmp_en;
    logic cap_rise;
    logic cap_fall;
    logic match_en;
    logic toggle_en;
    logic pwm_en;
    logic evt_ie;
  } cca_mode_t;

  // Whole state of the block
  typedef struct packed {
    logic [15:0] cnt;
    logic [7:0] snap;
    logic ovf_flag;
    logic run_ctl;
    logic [5:0] evt_flag;
    logic idle_susp;
    logic [2:0] tb_sel;
    logic ovf_ie;
    cca_mode_t [5:0] mode;
    logic [5:0][15:0] cc;
    logic [3:0] pre;
    logic [2:0] osc_div;
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] lvl;
    logic [7:0] rdata;
    logic irq;
  } cca_state_t;

endpackage

// ---- dv/cca_pin_model.sv ----
/*
  Pin-side model: capture lines, count pin and oscillator pin.
  Assumes one clock shared with the block and tasks called by the bench.
*/
`timescale 1ns/1ps
module cca_pin_model (
  input wire logic clk,
  output logic ext_count_in,
  output logic ext_osc_in,
  output logic [5:0] module_io_line
);
  logic [7:0] pins = 8'h00;
  // Bits 0-5 capture lines, 6 count pin, 7 oscillator
  assign {ext_osc_in, ext_count_in, module_io_line} = pins;
  // One level change, held three cycles
  task automatic drive(input int s, input logic v);
    @(posedge clk);
    pins[s] <= v;
    repeat (2) @(posedge clk);
  endtask
  // Square pulses on one pin
  task automatic pulses(input int s, input int n);
    repeat (n) begin
      drive(s, 1'b1);
      drive(s, 1'b0);
    end
  endtask
endmodule

// ---- dv/tb_counter_array_capture_compare.sv ----
/*
  Bench for the counter array: bus tasks, read scoreboard, scenarios.
  Assumes the pin model drives the capture, count and oscillator pins.
*/
`timescale 1ns/1ps
module tb_counter_array_capture_compare;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  cca_pkg::cca_req_t req = '0;
  logic [7:0] rd_data, md;
  logic irq, t0 = 1'b0, idle = 1'b0, gie = 1'b0, aie = 1'b0;
  logic ecnt, eosc, rdv = 1'b0;
  logic [5:0] lines;
  logic [31:0] seed = 32'hee23c5b6;
  logic [31:0] r, r2;
  logic [7:0] expq[$];
  logic [7:0] tb_cnt [8] = '{8'h0a, 8'h1e, 8'h03, 8'h04, 8'h78, 8'h02,
    8'h00, 8'h78};
  int n_errors = 0;
  int compares = 0;
  // Clock
  initial begin
    forever #10 clk = ~clk;
  end
  cca_counter_array dut (.clk(clk), .sys_rst(sys_rst), .req(req),
    .rd_data(rd_data), .timer0_ovf(t0), .ext_count_in(ecnt),
    .ext_osc_in(eosc), .module_io_line(lines), .cpu_idle(idle),
    .global_irq_enable(gie), .array_irq_enable(aie), .irq(irq));
  cca_pin_model pm (.clk(clk), .ext_count_in(ecnt), .ext_osc_in(eosc),
    .module_io_line(lines));
  // Verdict
  task automatic end_of_test;
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_irq(input logic e);
    chk({7'h00, e}, {7'h00, irq});
  endtask
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // One bus cycle per call
  task automatic op(input logic w, input logic [4:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    op(1'b1, a, d);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    expq.push_back(e);
    op(1'b0, a, 8'h00);
  endtask
  task automatic nop(input int n);
    req <= '0;
    repeat (n) @(posedge clk);
  endtask
  task automatic setc(input logic [15:0] v);
    wr(cca_pkg::ADDR_CNT_LO, v[7:0]);
    wr(cca_pkg::ADDR_CNT_HI, v[15:8]);
  endtask
  // Counter runs for n edges while pins are stimulated
  task automatic run(input int n, input int k, input logic [7:0] f);
    wr(cca_pkg::ADDR_CTRL, 8'h40);
    fork
      nop(n - 2);
      case (k)
        2: repeat (3) begin
          @(posedge clk);
          t0 <= 1'b1;
          @(posedge clk);
          t0 <= 1'b0;
        end
        3: pm.pulses(6, 4);
        5: pm.pulses(7, 16);
        default: ;
      endcase
    join
    // Flags seen while running, before the stop write clears them
    rd(cca_pkg::ADDR_CTRL, 8'h40 | f);
    wr(cca_pkg::ADDR_CTRL, 8'h00);
  endtask
  // Read data stands the cycle after the strobe
  always @(posedge clk) rdv <= req.rd;
  always @(negedge clk) begin
    if (rdv) chk(expq.pop_front(), rd_data);
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
  // Scenarios
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    wr(5'h1f, 8'hff);
    rd(cca_pkg::ADDR_CTRL, 8'h00);
    rd(cca_pkg::ADDR_MODE, 8'h00);
    rd(5'h1f, 8'h00);
    rd(cca_pkg::ADDR_MMODE0, 8'h00);
    for (int k = 0; k < 8; k++) begin
      md = k < 6 ? {4'h0, k[2:0], 1'b0} : {k == 6, 6'h04, 1'b0};
      wr(cca_pkg::ADDR_MODE, md);
      idle <= k > 5;
      setc(16'h0000);
      run(120, k, 8'h00);
      rd(cca_pkg::ADDR_CNT_LO, tb_cnt[k]);
    end
    idle <= 1'b0;
    setc(16'hfff8);
    run(10, 0, 8'h80);
    wr(cca_pkg::ADDR_CTRL, 8'h80);
    rd(cca_pkg::ADDR_CNT_LO, 8'h02);
    rd(cca_pkg::ADDR_CNT_HI, 8'h00);
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      wr(cca_pkg::ADDR_MODE, {7'h04, r[0]});
      gie <= r[1];
      aie <= r[2];
      nop(3);
      chk_irq(&r[2:0]);
    end
    rd(cca_pkg::ADDR_CTRL, 8'h80);
    wr(cca_pkg::ADDR_CTRL, 8'h00);
    rd(cca_pkg::ADDR_CTRL, 8'h00);
    // Control write in the wrap cycle
    setc(16'hffff);
    wr(cca_pkg::ADDR_CTRL, 8'h40);
    wr(cca_pkg::ADDR_CTRL, 8'h40);
    wr(cca_pkg::ADDR_CTRL, 8'h00);
    rd(cca_pkg::ADDR_CTRL, 8'h00);
    // Software sees the high byte wrap and restores the flag
    rd(cca_pkg::ADDR_CNT_LO, 8'h01);
    rd(cca_pkg::ADDR_CNT_HI, 8'h00);
    wr(cca_pkg::ADDR_CTRL, 8'h80);
    rd(cca_pkg::ADDR_CTRL, 8'h80);
    wr(cca_pkg::ADDR_CTRL, 8'h00);
    setc(16'h5aa5);
    rd(cca_pkg::ADDR_CNT_LO, 8'ha5);
    wr(cca_pkg::ADDR_CNT_HI, 8'h3c);
    rd(cca_pkg::ADDR_CNT_HI, 8'h5a);
    // Capture: rise, fall, both, odd modules with event interrupt
    gie <= 1'b1;
    aie <= 1'b1;
    wr(cca_pkg::ADDR_MODE, 8'h08);
    for (int i = 0; i < 6; i++) begin
      md = {2'b00, i % 3 != 1, i % 3 != 0, 3'b000, i[0]};
      r = rnd();
      r2 = rnd();
      wr(cca_pkg::ADDR_MMODE0 + 5'(i), md);
      setc(r[15:0]);
      nop(1);
      pm.drive(i, 1'b1);
      nop(3);
      setc(r2[15:0]);
      nop(1);
      pm.drive(i, 1'b0);
      nop(3);
      rd(cca_pkg::ADDR_CCLO0 + 5'(i), md[4] ? r2[7:0] : r[7:0]);
      rd(cca_pkg::ADDR_CCHI0 + 5'(i), md[4] ? r2[15:8] : r[15:8]);
      rd(cca_pkg::ADDR_CTRL, 8'h01 << i);
      chk_irq(i[0]);
      wr(cca_pkg::ADDR_CTRL, 8'h00);
    end
    // Software timer and value write order
    wr(cca_pkg::ADDR_MMODE0, 8'h48);
    wr(cca_pkg::ADDR_CCHI0, 8'h00);
    wr(cca_pkg::ADDR_CCLO0, 8'h10);
    rd(cca_pkg::ADDR_MMODE0, 8'h08);
    setc(16'h0008);
    run(20, 0, 8'h00);
    rd(cca_pkg::ADDR_CTRL, 8'h00);
    wr(cca_pkg::ADDR_CCHI0, 8'h00);
    rd(cca_pkg::ADDR_MMODE0, 8'h48);
    setc(16'h0008);
    run(20, 0, 8'h01);
    rd(cca_pkg::ADDR_CNT_LO, 8'h1c);
    nop(2);
    end_of_test();
  end
endmodule
